/* include/sfp_pkg.sv */
package sfp_pkg;
  // Register byte offsets
  localparam logic [7:0] SFP_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SFP_STAT_OFS   = 8'h04;
  localparam logic [7:0] SFP_IEN_OFS    = 8'h08;
  localparam logic [7:0] SFP_TXD_OFS    = 8'h0C;
  localparam logic [7:0] SFP_RXD_OFS    = 8'h10;
  localparam logic [7:0] SFP_TCD_OFS    = 8'h14;
  localparam logic [7:0] SFP_RCD_OFS    = 8'h18;
  localparam logic [7:0] SFP_CFG_OFS    = 8'h1C;
  // Control register fields
  localparam int SFP_C_TXE   = 0;
  localparam int SFP_C_RXE   = 1;
  localparam int SFP_C_TX_PARTIAL_RESET = 2;
  localparam int SFP_C_RX_PARTIAL_RESET = 3;
  localparam int SFP_C_STOP  = 4;
  localparam int SFP_C_SLAVE = 5;
  // Status register fields
  localparam int SFP_S_TX_FIFO_REQUEST = 0;
  localparam int SFP_S_RX_FIFO_REQUEST = 1;
  localparam int SFP_S_TX_CTRL_READY = 2;
  localparam int SFP_S_RX_CTRL_READY = 3;
  localparam int SFP_S_TX_FIFO_EMPTY = 4;
  localparam int SFP_S_RX_FIFO_FULL = 5;
  localparam int SFP_S_TX_UNDERFLOW_FLAG = 6;
  localparam int SFP_S_TX_OVERFLOW_FLAG = 7;
  localparam int SFP_S_RX_OVERFLOW_FLAG = 8;
  localparam int SFP_S_RX_UNDERFLOW_FLAG = 9;
  localparam int SFP_S_FRAME_SYNC_ERROR = 10;
  localparam int SFP_S_W     = 11;
  // Config field positions: threshold, frame bits
  localparam int SFP_F_TTH   = 0;
  localparam int SFP_F_RTH   = 8;
  localparam int SFP_F_BITS  = 16;
  // Sizes and reset values
  localparam int SFP_DW      = 16;
  localparam int SFP_AW      = 4;
  localparam logic [4:0] SFP_DEPTH = 5'h10;
  localparam logic [31:0] SFP_CFG_RST = 32'h0010_0804;
  localparam logic [31:0] SFP_RDATA_RST = 32'h0000_0000;
endpackage

/* hdl/sfp_core.sv */
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - Separate self-clearing transmit and receive reset bits
// - Transmit reset clears tx data, pointers, flags
// - Receive reset clears rx data, pointers, flags
// - Module stop halts shifting, keeps registers
// - Four interrupt lines: tx, rx, control, error
// - Transmit request when free space at or above threshold
// - Receive request when level above threshold
// - Control line merges four ready/fifo factors
// - Tx underflow on empty slot, overflow on full write
// - Rx overflow on full arrival, underflow on empty read
// - Slave early sync sets frame sync error
// - Factor reaches line only when enabled
// - Request flag cleared by low status or ack
// - Underrun resends previous transmitted word
// - Overrun write discarded, fifo kept
// - Receive overrun word discarded
// - Empty read returns last word read
// - Sync error restarts bit counter
// - Reading rx control data clears ready
module sfp_core
  import sfp_pkg::*;
(
  // System
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial link
  input  wire logic        sclk_in,
  input  wire logic        fsync_in,
  input  wire logic        rxd_in,
  output logic             txd_out,
  // Interrupts and DMA
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             control_irq,
  output logic             error_irq,
  input  wire logic        tx_dma_ack,
  input  wire logic        rx_dma_ack
);
  // Registers
  logic [31:0] ctrl, ien, cfg;
  logic [SFP_S_W-1:0] stat_err;
  logic [SFP_DW-1:0] tx_data_reg, rx_data_reg, tcd, rx_control_data_reg;
  logic tx_ctrl_ready, rx_ctrl_ready;
  logic [SFP_DW-1:0] tx_mem [0:15];
  logic [SFP_DW-1:0] rx_mem [0:15];
  logic [SFP_AW:0] twp, trp, rwp, rrp;
  logic [SFP_DW-1:0] tx_sh, rx_sh, last_tx;
  logic [7:0] bitcnt;
  logic tx_irq_flag, rx_irq_flag;
  logic [2:0] sclk_s;
  logic [1:0] fs_s, rxd_s;
  // Sync level seen at the previous sampling edge
  logic fs_prev;
  // Bus address phase capture
  logic ph_wr, ph_rd;
  logic [7:0] ph_addr;

  function automatic logic [SFP_AW:0] lvl(input logic [SFP_AW:0] w, input logic [SFP_AW:0] r);
    lvl = w - r;
  endfunction

  // Decode
  wire acc = hsel & hready & htrans[1];
  wire wr_ctrl = ph_wr & (ph_addr == SFP_CTRL_OFS);
  wire wr_ien  = ph_wr & (ph_addr == SFP_IEN_OFS);
  wire wr_cfg  = ph_wr & (ph_addr == SFP_CFG_OFS);
  wire wr_stat = ph_wr & (ph_addr == SFP_STAT_OFS);
  wire wr_txd  = ph_wr & (ph_addr == SFP_TXD_OFS);
  wire wr_tcd  = ph_wr & (ph_addr == SFP_TCD_OFS);
  wire rd_rxd  = acc & ~hwrite & (haddr == SFP_RXD_OFS);
  wire rd_rcd  = acc & ~hwrite & (haddr == SFP_RCD_OFS);
  wire tx_rst  = wr_ctrl & hwdata[SFP_C_TX_PARTIAL_RESET];
  wire rx_rst  = wr_ctrl & hwdata[SFP_C_RX_PARTIAL_RESET];
  wire stopped = ctrl[SFP_C_STOP];
  wire tx_enable_bit     = ctrl[SFP_C_TXE];
  wire rx_enable_bit     = ctrl[SFP_C_RXE];

  // FIFO levels and status
  wire [SFP_AW:0] tlvl = lvl(twp, trp);
  wire [SFP_AW:0] rlvl = lvl(rwp, rrp);
  wire tx_fifo_empty = (tlvl == 5'h00);
  wire tx_fifo_full  = (tlvl == SFP_DEPTH);
  wire rx_fifo_empty = (rlvl == 5'h00);
  wire rx_fifo_full  = (rlvl == SFP_DEPTH);
  wire tx_fifo_request = tx_enable_bit & ((SFP_DEPTH - tlvl) >= cfg[SFP_F_TTH +: 5]);
  wire rx_fifo_request = rx_enable_bit & (rlvl > cfg[SFP_F_RTH +: 5]);

  // Link edges: synchronised sclk, sample on falling edge
  wire sclk_fall = sclk_s[2] & ~sclk_s[1];
  wire fs_rise   = fs_s[1] & ~fs_prev;                         // Sync judged at the sampling edge
  wire run       = ~stopped;
  wire tick      = run & sclk_fall;
  wire frame_end = (bitcnt == cfg[SFP_F_BITS +: 8] - 8'h01);
  wire fs_early  = tick & fs_rise & ctrl[SFP_C_SLAVE] & (bitcnt != 8'h00);
  wire word_start = tick & (fs_rise | (bitcnt == 8'h00));
  wire tx_slot   = word_start & tx_enable_bit;
  wire rx_done   = tick & rx_enable_bit & frame_end & ~fs_rise;
  wire tx_pop    = tx_slot & ~tx_fifo_empty;
  wire tx_push   = wr_txd & ~tx_fifo_full & ~tx_rst;
  wire rx_push   = rx_done & ~rx_fifo_full;
  wire rx_pop    = rd_rxd & ~rx_fifo_empty;

  // Error events
  wire [SFP_S_W-1:0] err_set;
  assign err_set[SFP_S_TX_UNDERFLOW_FLAG] = tx_slot & tx_fifo_empty;
  assign err_set[SFP_S_TX_OVERFLOW_FLAG] = wr_txd & tx_fifo_full;
  assign err_set[SFP_S_RX_OVERFLOW_FLAG] = rx_done & rx_fifo_full;
  assign err_set[SFP_S_RX_UNDERFLOW_FLAG] = rd_rxd & rx_fifo_empty;
  assign err_set[SFP_S_FRAME_SYNC_ERROR] = fs_early;
  assign err_set[5:0] = 6'h00;

  wire [SFP_S_W-1:0] stat = stat_err | {5'h00, rx_fifo_full, tx_fifo_empty & tx_enable_bit,
                            rx_ctrl_ready, tx_ctrl_ready, rx_fifo_request, tx_fifo_request};
  wire [SFP_S_W-1:0] fac = stat & ien[SFP_S_W-1:0];
  wire next_ctl = |fac[SFP_S_RX_FIFO_FULL:SFP_S_TX_CTRL_READY];
  wire next_err = |fac[SFP_S_FRAME_SYNC_ERROR:SFP_S_TX_UNDERFLOW_FLAG];

  // Bus read mux
  wire [31:0] next_rdata =
    (haddr == SFP_CTRL_OFS) ? ctrl :
    (haddr == SFP_STAT_OFS) ? {21'h0, stat} :
    (haddr == SFP_IEN_OFS)  ? ien :
    (haddr == SFP_CFG_OFS)  ? cfg :
    (haddr == SFP_TXD_OFS)  ? {16'h0, tx_data_reg} :
    (haddr == SFP_TCD_OFS)  ? {16'h0, tcd} :
    (haddr == SFP_RXD_OFS)  ? {16'h0, rx_fifo_empty ? rx_data_reg : rx_mem[rrp[3:0]]} :
    (haddr == SFP_RCD_OFS)  ? {16'h0, rx_control_data_reg} : SFP_RDATA_RST;

  // Synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_s <= 3'h0;
      fs_s   <= 2'h0;
      rxd_s  <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk_in};
      fs_s   <= {fs_s[0], fsync_in};
      rxd_s  <= {rxd_s[0], rxd_in};
    end
  end

  // Bus slave: always zero wait, OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 8'h00;
      hrdata <= SFP_RDATA_RST;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ph_wr <= acc & hwrite;
      ph_rd <= acc & ~hwrite;
      ph_addr <= haddr;
      hrdata <= (acc & ~hwrite) ? next_rdata : SFP_RDATA_RST;
    end
  end

  // Control, enable and config registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= 32'h0;
      ien  <= 32'h0;
      cfg  <= SFP_CFG_RST;
    end else begin
      if (wr_ctrl) ctrl <= {26'h0, hwdata[5:4], 2'b00, hwdata[1:0]};
      if (tx_rst) ctrl[SFP_C_TXE] <= 1'b0;
      if (rx_rst) ctrl[SFP_C_RXE] <= 1'b0;
      if (wr_ien) ien <= {21'h0, hwdata[SFP_S_W-1:0]};
      if (wr_cfg) cfg <= hwdata;
    end
  end

  // Sticky errors: write 1 to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stat_err <= '0;
    else stat_err <= (stat_err & ~(wr_stat ? hwdata[SFP_S_W-1:0] : '0)) | err_set;
  end

  // Transmit FIFO and shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      twp <= '0;
      trp <= '0;
      tx_data_reg <= '0;
      tx_sh <= '0;
      last_tx <= '0;
      txd_out <= 1'b0;
    end else if (tx_rst) begin
      twp <= '0;
      trp <= '0;
      tx_data_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_mem[twp[3:0]] <= hwdata[SFP_DW-1:0];
        tx_data_reg <= hwdata[SFP_DW-1:0];
        twp <= twp + 5'h01;
      end
      if (tx_slot) begin
        tx_sh <= tx_pop ? tx_mem[trp[3:0]] : last_tx;
        txd_out <= tx_pop ? tx_mem[trp[3:0]][SFP_DW-1] : last_tx[SFP_DW-1];
        if (tx_pop) begin
          last_tx <= tx_mem[trp[3:0]];
          trp <= trp + 5'h01;
        end
      end else if (tick) begin
        tx_sh <= {tx_sh[SFP_DW-2:0], 1'b0};
        txd_out <= tx_sh[SFP_DW-2];
      end
    end
  end

  // Bit counter and receive path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bitcnt <= 8'h00;
      fs_prev <= 1'b0;
      rx_sh <= '0;
      rwp <= '0;
      rrp <= '0;
      rx_data_reg <= '0;
    end else begin
      if (tick) begin
        bitcnt <= fs_rise ? 8'h01 : frame_end ? 8'h00 : bitcnt + 8'h01;
        fs_prev <= fs_s[1];
        rx_sh <= {rx_sh[SFP_DW-2:0], rxd_s[1]};
      end
      if (rx_rst) begin
        rwp <= '0;
        rrp <= '0;
        rx_data_reg <= '0;
      end else begin
        if (rx_push) begin
          rx_mem[rwp[3:0]] <= {rx_sh[SFP_DW-2:0], rxd_s[1]};
          rwp <= rwp + 5'h01;
        end
        if (rx_pop) begin
          rx_data_reg <= rx_mem[rrp[3:0]];
          rrp <= rrp + 5'h01;
        end
      end
    end
  end

  // Control data ready flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ctrl_ready <= 1'b1;
      rx_ctrl_ready <= 1'b0;
      tcd <= '0;
      rx_control_data_reg <= '0;
    end else begin
      if (tx_rst) tx_ctrl_ready <= 1'b0;
      else if (wr_tcd) begin
        tcd <= hwdata[SFP_DW-1:0];
        tx_ctrl_ready <= 1'b0;
      end else if (rx_done) tx_ctrl_ready <= 1'b1;
      if (rx_rst) rx_ctrl_ready <= 1'b0;
      else if (rx_done & ~tx_ctrl_ready) begin                   // Set wins over read
        rx_control_data_reg <= {rx_sh[SFP_DW-2:0], rxd_s[1]};
        rx_ctrl_ready <= 1'b1;
      end else if (rd_rcd) rx_ctrl_ready <= 1'b0;
    end
  end

  // Request lines: factor held unless the DMA has just acknowledged it
  wire next_tx_req = fac[SFP_S_TX_FIFO_REQUEST] & ~(tx_dma_ack & tx_irq_flag);
  wire next_rx_req = fac[SFP_S_RX_FIFO_REQUEST] & ~(rx_dma_ack & rx_irq_flag);

  // Request flags toward interrupt and DMA controllers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_irq_flag <= 1'b0;
      rx_irq_flag <= 1'b0;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      control_irq <= 1'b0;
      error_irq <= 1'b0;
    end else begin
      tx_irq_flag <= next_tx_req;
      rx_irq_flag <= next_rx_req;
      tx_irq <= next_tx_req;
      rx_irq <= next_rx_req;
      control_irq <= next_ctl;
      error_irq <= next_err;
    end
  end

  // Checks
  tx_reset_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_rst |=> (twp == 5'h00) && (trp == 5'h00) && !ctrl[SFP_C_TXE]) else $error("tx reset incomplete");
  rx_reset_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_rst |=> (rwp == 5'h00) && !rx_ctrl_ready && !ctrl[SFP_C_RXE]) else $error("rx reset incomplete");
  stop_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (stopped && !acc && !ph_wr) |=> $stable(trp) && $stable(rwp)) else $error("stop moved fifo");
  tx_ovf_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_txd && tx_fifo_full && !tx_rst) |=> $stable(twp) && stat_err[SFP_S_TX_OVERFLOW_FLAG]) else $error("overflow write kept");
  tx_udf_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_slot && tx_fifo_empty) |=> stat_err[SFP_S_TX_UNDERFLOW_FLAG]) else $error("underflow not flagged");
  rx_ovf_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_done && rx_fifo_full && !rx_rst && !rd_rxd) |=> $stable(rwp) && stat_err[SFP_S_RX_OVERFLOW_FLAG]) else $error("rx overflow stored");
  fs_err_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fs_early |=> stat_err[SFP_S_FRAME_SYNC_ERROR] && (bitcnt == 8'h01)) else $error("sync error not handled");
  err_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ien[SFP_S_W-1:0] == '0) |=> !error_irq && !control_irq) else $error("masked factor raised line");
  ack_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_dma_ack && tx_irq_flag) |=> !tx_irq) else $error("ack did not clear");
  rcd_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_rcd && !rx_done && !rx_rst) |=> !rx_ctrl_ready) else $error("rx ready not cleared");

  // Further checks on bus, link and request lines
  // Read data stands only in a read data phase
  rd_idle_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ph_rd |-> (hrdata == SFP_RDATA_RST)) else $error("read data outside data phase");
  // Empty receive read is flagged
  rx_udf_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_rxd && rx_fifo_empty) |=> stat_err[SFP_S_RX_UNDERFLOW_FLAG]) else $error("rx underflow not flagged");
  // Enabled control factor reaches its line
  ctl_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
    next_ctl |=> control_irq) else $error("control line missing");
  // Enabled error factor reaches its line
  err_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
    next_err |=> error_irq) else $error("error line missing");
  // Receive acknowledge drops the receive line
  rx_ack_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_dma_ack && rx_irq_flag) |=> !rx_irq) else $error("rx ack did not clear");
  // Underrun slot reloads the previous word
  udf_resend_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tx_slot && tx_fifo_empty && !tx_rst) |=> (tx_sh == $past(last_tx))) else $error("previous word not resent");
  // Stored receive word advances the write pointer
  rx_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_push && !rx_rst) |=> (rwp == $past(rwp) + 5'h01)) else $error("rx word not stored");
  // Accepted transmit write advances the write pointer
  tx_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_push |=> (twp == $past(twp) + 5'h01)) else $error("tx word not stored");
  // Stopped module holds counter and output bit
  stop_link_a: assert property (@(posedge hclk) disable iff (!hresetn)
    stopped |=> $stable(bitcnt) && $stable(txd_out)) else $error("stop moved link");
  // Completed frame restarts the bit counter
  frame_wrap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick && frame_end && !fs_rise) |=> (bitcnt == 8'h00)) else $error("frame did not wrap");
  // Transmit reset clears data and ready flag
  tx_rst_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_rst |=> !tx_ctrl_ready && (tx_data_reg == 16'h0000)) else $error("tx data not cleared");
  // Receive reset clears data and read pointer
  rx_rst_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_rst |=> (rx_data_reg == 16'h0000) && (rrp == 5'h00)) else $error("rx data not cleared");
  // Masked transmit request keeps its line low
  tx_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !ien[SFP_S_TX_FIFO_REQUEST] |=> !tx_irq) else $error("masked tx request raised line");
  // Enabled transmit request raises its line
  tx_req_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
    next_tx_req |=> tx_irq) else $error("tx request line missing");
  // Enabled receive request raises its line
  rx_req_line_a: assert property (@(posedge hclk) disable iff (!hresetn)
    next_rx_req |=> rx_irq) else $error("rx request line missing");
  // Completed frame with pending control captures it
  rcd_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rx_done && !tx_ctrl_ready && !rx_rst) |=> rx_ctrl_ready) else $error("rx control not captured");
endmodule

/* tb/sfp_codec_model.sv */
`timescale 1ns/1ps
// Codec side of the link: clock and sync move only inside frames, data flips once after each frame
module sfp_codec_model (
  // Link lines
  output logic      sclk,
  output logic      fsync,
  output logic      rxd,
  input  wire logic txd
);
  logic [15:0] heard;
  // Idle link: clock stands still low
  initial begin
    sclk = 1'b0;
    fsync = 1'b0;
    rxd = 1'b0;
    heard = 16'h0000;
  end
  // One frame of nbits, MSB first, sync pulse with the first bit
  // Lines change mid low phase, stable across the sampling fall
  task automatic frame(input int nbits, input logic [15:0] word);
    for (int i = 0; i < nbits; i++) begin
      fsync = (i == 0);
      rxd = word[15 - i];
      #200 sclk = 1'b1;
      heard = {heard[14:0], txd}; // Bit launched after the previous fall
      #400 sclk = 1'b0;
      #200;
    end
    fsync = 1'b0;
    rxd = ~rxd; // Released line must not show a stale bit
    #400 heard = {heard[14:0], txd};
    #400;
  endtask
endmodule

/* tb/test_serial_fifo_reset_irq_error.sv */
`timescale 1ns/1ps
module test_serial_fifo_reset_irq_error
  import sfp_pkg::*;
();
  // Stimulus and observed lines
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        tx_dma_ack = 1'b0;
  logic        rx_dma_ack = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic        hreadyout, hresp, txd, sclk, fsync, rxd, low_seen;
  logic        tx_irq, rx_irq, control_irq, error_irq;
  int          fails = 0;
  int          checks = 0;
  // Status and control masks
  localparam logic [31:0] K_TDQ = 32'h1 << SFP_S_TX_FIFO_REQUEST;
  localparam logic [31:0] K_RDQ = 32'h1 << SFP_S_RX_FIFO_REQUEST;
  localparam logic [31:0] K_TEM = 32'h1 << SFP_S_TX_FIFO_EMPTY;
  localparam logic [31:0] K_RCR = 32'h1 << SFP_S_RX_CTRL_READY;
  localparam logic [31:0] K_RFL = 32'h1 << SFP_S_RX_FIFO_FULL;
  localparam logic [31:0] K_TUF = 32'h1 << SFP_S_TX_UNDERFLOW_FLAG;
  localparam logic [31:0] K_TOV = 32'h1 << SFP_S_TX_OVERFLOW_FLAG;
  localparam logic [31:0] K_ROV = 32'h1 << SFP_S_RX_OVERFLOW_FLAG;
  localparam logic [31:0] K_RUF = 32'h1 << SFP_S_RX_UNDERFLOW_FLAG;
  localparam logic [31:0] K_FSE = 32'h1 << SFP_S_FRAME_SYNC_ERROR;
  localparam logic [31:0] C_TXE = 32'h1 << SFP_C_TXE;
  localparam logic [31:0] C_RXE = 32'h1 << SFP_C_RXE;
  localparam logic [31:0] C_TRS = 32'h1 << SFP_C_TX_PARTIAL_RESET;
  localparam logic [31:0] C_RRS = 32'h1 << SFP_C_RX_PARTIAL_RESET;
  localparam logic [31:0] C_STP = 32'h1 << SFP_C_STOP;
  localparam logic [31:0] C_SLV = 32'h1 << SFP_C_SLAVE;

  always #50 hclk = ~hclk;

  // Design and far-side codec
  sfp_core sfp_core_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sclk_in(sclk), .fsync_in(fsync), .rxd_in(rxd),
    .txd_out(txd), .tx_irq(tx_irq), .rx_irq(rx_irq), .control_irq(control_irq),
    .error_irq(error_irq), .tx_dma_ack(tx_dma_ack), .rx_dma_ack(rx_dma_ack)
  );
  sfp_codec_model sfp_codec_model_inst (.sclk(sclk), .fsync(fsync), .rxd(rxd), .txd(txd));

  // Counts, verdict and end of run
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compare a register value
  task automatic check_reg(input string name, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask
  // Compare a single line
  task automatic check_line(input string name, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %b seen %b", name, e, g);
    end
  endtask
  // Bounded wait for hready high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        complete_run();
      end
      @(posedge hclk);
    end
  endtask
  // One single-word AHB-Lite transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  // Read a register and compare the bits under a mask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string name);
    bus(1'b0, a, 32'h0);
    check_reg(name, e & m, q & m);
  endtask
  // Full-length frames with a counting pattern
  task automatic frames(input int n);
    for (int i = 0; i < n; i++) begin
      sfp_codec_model_inst.frame(16, 16'hA5C3 ^ 16'(i));
    end
  endtask

  // Hang guard
  initial begin
    #5000000;
    fails++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset state: requests stay low until a direction is enabled
    rd(SFP_STAT_OFS, K_TDQ | K_RDQ | K_TEM | K_RFL, 32'h0, "reset status");
    bus(1'b1, SFP_CTRL_OFS, C_SLV | C_TXE | C_RXE);
    rd(SFP_STAT_OFS, K_TDQ | K_TEM, K_TDQ | K_TEM, "tx enabled empty");
    // Transmit fifo written past its depth
    for (int i = 0; i < 17; i++) begin
      bus(1'b1, SFP_TXD_OFS, 32'(i));
    end
    rd(SFP_STAT_OFS, K_TDQ | K_TEM | K_TOV, K_TOV, "tx overflow");
    rd(SFP_TXD_OFS, 32'hFFFF, 32'h0000000F, "tx data kept");
    // Error line follows its enable and the flag clear
    check_line("error_irq masked", 1'b0, error_irq);
    bus(1'b1, SFP_IEN_OFS, K_TOV);
    repeat (3) @(posedge hclk);
    check_line("error_irq", 1'b1, error_irq);
    bus(1'b1, SFP_STAT_OFS, K_TOV);
    repeat (3) @(posedge hclk);
    check_line("error_irq cleared", 1'b0, error_irq);
    // Transmit reset leaves the receive side enabled
    bus(1'b1, SFP_CTRL_OFS, C_SLV | C_RXE | C_TRS);
    rd(SFP_STAT_OFS, K_TDQ | K_TEM, 32'h0, "tx after reset");
    rd(SFP_TXD_OFS, 32'hFFFF, 32'h0, "tx data after reset");
    rd(SFP_CTRL_OFS, C_TXE | C_RXE | C_SLV, C_RXE | C_SLV, "ctrl after tx reset");
    // DMA acknowledge drops the transmit request line
    bus(1'b1, SFP_CTRL_OFS, C_SLV | C_RXE | C_TXE);
    bus(1'b1, SFP_IEN_OFS, K_TDQ);
    repeat (3) @(posedge hclk);
    check_line("tx_irq", 1'b1, tx_irq);
    tx_dma_ack <= 1'b1;
    @(posedge hclk);
    tx_dma_ack <= 1'b0;
    low_seen = 1'b0;
    repeat (3) begin
      @(posedge hclk);
      if (tx_irq === 1'b0) low_seen = 1'b1;
    end
    check_line("tx_irq after ack", 1'b1, low_seen);
    // Receive fifo overfilled by the codec
    frames(17);
    rd(SFP_STAT_OFS, K_RDQ | K_RFL | K_ROV, K_RDQ | K_RFL | K_ROV, "rx full");
    // Control exchange: check ready, write tx control, then read the received control word to clear
    rd(SFP_STAT_OFS, K_RCR, K_RCR, "rx ctrl ready");
    bus(1'b1, SFP_TCD_OFS, 32'h0000_1234);
    rd(SFP_RCD_OFS, 32'hFFFF, 32'h0000A5C3, "rx ctrl data");
    rd(SFP_STAT_OFS, K_RCR, 32'h0, "rx ctrl cleared");
    bus(1'b1, SFP_IEN_OFS, K_RDQ | K_RFL);
    repeat (3) @(posedge hclk);
    check_line("rx_irq", 1'b1, rx_irq);
    check_line("control_irq", 1'b1, control_irq);
    rx_dma_ack <= 1'b1;
    @(posedge hclk);
    rx_dma_ack <= 1'b0;
    low_seen = 1'b0;
    repeat (3) begin
      @(posedge hclk);
      if (rx_irq === 1'b0) low_seen = 1'b1;
    end
    check_line("rx_irq after ack", 1'b1, low_seen);
    // Drain: the overflowing word is gone, then an empty read
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, SFP_RXD_OFS, 32'h0);
    end
    check_reg("last drained word", 32'h0000A5CC, q & 32'hFFFF);
    bus(1'b0, SFP_RXD_OFS, 32'h0);
    check_reg("empty read data", 32'h0000A5CC, q & 32'hFFFF);
    rd(SFP_STAT_OFS, K_RUF | K_RFL, K_RUF, "rx underflow");
    // Stopped module takes in nothing and keeps its control bits
    bus(1'b1, SFP_CTRL_OFS, C_SLV | C_RXE | C_STP);
    frames(9);
    rd(SFP_STAT_OFS, K_RDQ, 32'h0, "rx while stopped");
    rd(SFP_CTRL_OFS, C_SLV | C_RXE | C_STP, C_SLV | C_RXE | C_STP, "ctrl kept");
    bus(1'b1, SFP_CTRL_OFS, C_SLV | C_RXE);
    frames(9);
    rd(SFP_STAT_OFS, K_RDQ, K_RDQ, "rx above threshold");
    // Receive reset clears level flags and the enable
    bus(1'b1, SFP_CTRL_OFS, C_SLV | C_RXE | C_RRS);
    rd(SFP_STAT_OFS, K_RDQ | K_RFL, 32'h0, "rx after reset");
    rd(SFP_CTRL_OFS, C_RXE | C_SLV, C_SLV, "ctrl after rx reset");
    // Transmit slot with one queued word, then with an empty fifo
    bus(1'b1, SFP_CTRL_OFS, C_SLV | C_TXE);
    bus(1'b1, SFP_TXD_OFS, 32'h0000_5A3C);
    bus(1'b1, SFP_STAT_OFS, K_TUF);
    frames(1);
    check_reg("word sent", 32'h0000_5A3C, {16'h0000, sfp_codec_model_inst.heard});
    rd(SFP_STAT_OFS, K_TUF, 32'h0, "no underflow");
    frames(1);
    rd(SFP_STAT_OFS, K_TUF, K_TUF, "tx underflow");
    check_reg("word resent", 32'h0000_5A3C, {16'h0000, sfp_codec_model_inst.heard});
    // Early sync inside a frame
    sfp_codec_model_inst.frame(5, 16'hFFFF);
    frames(1);
    rd(SFP_STAT_OFS, K_FSE, K_FSE, "frame sync error");
    complete_run();
  end
endmodule
